// ---- rtl/dma_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl #(
  parameter int NCH = 4
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [dma_pkg::N_TRIG-1:0] i_trig,
  input  wire logic [15:0]          i_adc_offset,
  output dma_pkg::ds_req_t          o_ds,
  input  wire logic                 i_ds_ack,
  input  wire logic [15:0]          i_ds_rdata,
  output logic                      o_irq
);
  import dma_pkg::*;
  localparam int CW = $clog2(NCH);
  initial begin
    if (NCH < 2 || NCH > 8) $error("channel count must be 2..8");
  end
  // ==========================================================================
  // per-channel configuration
  logic [15:0] ctrl_q [NCH];
  logic [5:0]  tsel_q [NCH];
  logic [15:0] cnt_q  [NCH];
  logic [15:0] rem_q  [NCH];
  logic [15:0] src_q  [NCH];
  logic [15:0] dst_q  [NCH];
  logic [15:0] lower_q, upper_q;
  logic [2*NCH-1:0] stat_q, mask_q; // low half done, high half limit error
  logic [NCH-1:0] pend_q, busy_q;
  logic [CW-1:0]  cur_q;
  xfer_state_t    st_q;
  logic [15:0]    data_q, sa_q, da_q;
  logic           rd_pend_q;
  logic [1:0]     acc_q;
  logic [N_TRIG-1:0] trig_m_q, trig_s_q, trig_prev_q;
  logic [15:0]    off_m_q, off_s_q;
  // the converter offset comes from its own logic, synchronised anyway
  always_ff @(posedge i_mclk) begin
    trig_m_q <= i_trig;
    trig_s_q <= trig_m_q;
    trig_prev_q <= trig_s_q;
    off_m_q <= i_adc_offset;
    off_s_q <= off_m_q;
  end
  // ==========================================================================
  // base addresses live in the small memory; shadow copies drive the stepping
  logic         ram_we;
  logic [3:0]   ram_wa, ram_ra;
  logic [15:0]  ram_wd, ram_rd;
  dma_regram #(.DEPTH(16), .AW(4)) u_base (
    .i_mclk  (i_mclk),
    .i_we    (ram_we),
    .i_waddr (ram_wa),
    .i_wdata (ram_wd),
    .i_raddr (ram_ra),
    .o_rdata (ram_rd)
  );

  function automatic logic [7:0] reg_sel(input logic [7:0] a);
    reg_sel = a & 8'h1c;
  endfunction
  function automatic logic [CW-1:0] ch_of(input logic [7:0] a);
    ch_of = CW'(a[7:5]);
  endfunction
  function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m,
                                       input logic byte_sz);
    logic [15:0] d;
    d = byte_sz ? 16'h0001 : 16'h0002;
    if (m == 2'h1) step = a + d;
    else if (m == 2'h2) step = a - d;
    else step = a;
  endfunction

  // ==========================================================================
  // bus slave: two wait cycles on every access, the second covers the memory's registered read
  logic is_ch, is_wr;
  assign is_ch = avs_address < G_LOWER && ch_of(avs_address) < NCH;
  assign is_wr = avs_write && !avs_waitrequest;
  // base writes land only at the edge that ends the wait, like every other register
  assign ram_we = is_wr && is_ch && (reg_sel(avs_address) == CH_SRC
                  || reg_sel(avs_address) == CH_DST);
  assign ram_wa = {2'(ch_of(avs_address)), reg_sel(avs_address) == CH_DST, 1'b0};
  assign ram_wd = avs_writedata[15:0];
  assign ram_ra = ram_wa;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      acc_q <= 2'h0;
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && acc_q == 2'h0) begin
      acc_q <= 2'h1;
    end else if (acc_q == 2'h1) begin
      acc_q <= 2'h2;
      avs_waitrequest <= 1'b0;
    end else begin
      acc_q <= 2'h0;
      avs_waitrequest <= 1'b1;
    end
  end

  // read mux
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      avs_readdata <= 32'h0;
    end else if (acc_q == 2'h1) begin
      if (is_ch && reg_sel(avs_address) == CH_CTRL) begin
        avs_readdata <= {15'h0, busy_q[ch_of(avs_address)], ctrl_q[ch_of(avs_address)]};
      end else if (is_ch && reg_sel(avs_address) == CH_TRIG) begin
        avs_readdata <= {26'h0, tsel_q[ch_of(avs_address)]};
      end else if (is_ch && (reg_sel(avs_address) == CH_SRC
                   || reg_sel(avs_address) == CH_DST)) begin
        avs_readdata <= {16'h0, ram_rd};
      end else if (is_ch && reg_sel(avs_address) == CH_CNT) begin
        avs_readdata <= {rem_q[ch_of(avs_address)], cnt_q[ch_of(avs_address)]};
      end else if (avs_address == G_LOWER) begin
        avs_readdata <= {16'h0, lower_q};
      end else if (avs_address == G_UPPER) begin
        avs_readdata <= {16'h0, upper_q};
      end else if (avs_address == G_STATUS) begin
        avs_readdata <= 32'(stat_q);
      end else if (avs_address == G_MASK) begin
        avs_readdata <= 32'(mask_q);
      end else begin
        avs_readdata <= 32'h0; // unmapped reads zero
      end
    end
  end

  // ==========================================================================
  // configuration writes; every channel owns its own control, trigger and count, while limits and mask are shared
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_q[c] <= CTRL_RESET;
        tsel_q[c] <= 6'h0;
        cnt_q[c]  <= 16'h0;
      end
      lower_q <= RAM_BASE;
      upper_q <= 16'hffff;
      mask_q  <= '0;
    end else if (is_wr) begin
      if (is_ch && reg_sel(avs_address) == CH_CTRL) begin
        ctrl_q[ch_of(avs_address)] <= avs_writedata[15:0];
      end else if (is_ch && reg_sel(avs_address) == CH_TRIG) begin
        tsel_q[ch_of(avs_address)] <= avs_writedata[5:0];
      end else if (is_ch && reg_sel(avs_address) == CH_CNT) begin
        cnt_q[ch_of(avs_address)] <= avs_writedata[15:0];
      end else if (avs_address == G_LOWER) begin
        lower_q <= avs_writedata[15:0];
      end else if (avs_address == G_UPPER) begin
        upper_q <= avs_writedata[15:0];
      end else if (avs_address == G_MASK) begin
        mask_q <= avs_writedata[2*NCH-1:0];
      end
    end
  end

  // ==========================================================================
  // trigger edge detect; index 0 is the highest-priority source, so the
  // table is reversed: trigger number n is source N_TRIG-1-n
  logic [NCH-1:0] hit;
  logic [NCH-1:0] done_ev;
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_trig
      logic [5:0] idx;
      assign idx = 6'(N_TRIG - 1) - tsel_q[c];
      // selected source fires, or a completion on any channel, its own included, chains it
      assign hit[c] = ctrl_q[c][F_EN] && ((idx < 6'(N_TRIG) && trig_s_q[idx]
                      && !trig_prev_q[idx]) || (tsel_q[c] == 6'h3f && |done_ev));
    end
  endgenerate

  // arbitration: lowest numbered pending channel wins
  logic [CW-1:0] win;
  logic          any_pend;
  always_comb begin
    win = '0;
    any_pend = 1'b0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (pend_q[c] && ctrl_q[c][F_EN]) begin
        win = CW'(c);
        any_pend = 1'b1;
      end
    end
  end

  // ==========================================================================
  // transfer engine
  logic in_lim_s, in_lim_d, last, cur_cont, lim_err;
  logic [15:0] ea_s, ea_d;
  mode_t cur_mode;
  assign cur_mode = mode_t'(ctrl_q[cur_q][F_MODE+:2]);
  assign cur_cont = cur_mode == M_CONT || cur_mode == M_REP_CONT;
  // base plus converter offset in indirect mode
  assign ea_s = ctrl_q[cur_q][F_SIND] ? sa_q + off_s_q : sa_q;
  assign ea_d = ctrl_q[cur_q][F_DIND] ? da_q + off_s_q : da_q;
  // register region is never limited; RAM must sit inside the window
  assign in_lim_s = ea_s <= SFR_TOP || (ea_s >= lower_q && ea_s <= upper_q);
  assign in_lim_d = ea_d <= SFR_TOP || (ea_d >= lower_q && ea_d <= upper_q);
  assign lim_err  = st_q == S_READ && !rd_pend_q && !(in_lim_s && in_lim_d);
  assign last = !cur_cont || rem_q[cur_q] <= 16'h1;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_q <= S_IDLE;
      cur_q <= '0;
      o_ds <= '0;
      rd_pend_q <= 1'b0;
      data_q <= 16'h0;
      sa_q <= 16'h0;
      da_q <= 16'h0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (any_pend) begin
            cur_q <= win;
            sa_q <= src_q[win];
            da_q <= dst_q[win];
            st_q <= S_READ;
          end
        end
        S_READ: begin
          if (lim_err) begin
            st_q <= S_IDLE; // aborted
          end else if (!rd_pend_q) begin
            o_ds <= '{req: 1'b1, we: 1'b0, addr: ea_s, be: 2'b11, wdata: 16'h0};
            rd_pend_q <= 1'b1;
          end else if (i_ds_ack) begin
            o_ds.req <= 1'b0;
            rd_pend_q <= 1'b0;
            // byte lane picked by address bit 0
            if (!ctrl_q[cur_q][F_SIZE]) begin
              data_q <= {8'h0, ea_s[0] ? i_ds_rdata[15:8] : i_ds_rdata[7:0]};
            end else begin
              data_q <= i_ds_rdata;
            end
            st_q <= S_WRITE;
          end
        end
        S_WRITE: begin
          if (!o_ds.req) begin
            o_ds.req <= 1'b1;
            o_ds.we <= 1'b1;
            o_ds.addr <= ea_d;
            o_ds.be <= ctrl_q[cur_q][F_SIZE] ? 2'b11 : (ea_d[0] ? 2'b10 : 2'b01);
            o_ds.wdata <= ctrl_q[cur_q][F_SIZE] ? data_q : {data_q[7:0], data_q[7:0]};
          end else if (i_ds_ack) begin
            o_ds <= '0;
            st_q <= S_STEP;
          end
        end
        default: begin
          // block sides step, fixed sides hold
          sa_q <= step(sa_q, ctrl_q[cur_q][F_SAM+:2], !ctrl_q[cur_q][F_SIZE]);
          da_q <= step(da_q, ctrl_q[cur_q][F_DAM+:2], !ctrl_q[cur_q][F_SIZE]);
          // continuous series runs on back to back while enabled
          st_q <= (cur_cont && !last && ctrl_q[cur_q][F_EN]) ? S_READ : S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // per-channel state: pending, busy, remaining count, working addresses
  logic step_now;
  assign step_now = st_q == S_STEP;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pend_q <= '0;
      busy_q <= '0;
      done_ev <= '0;
      for (int c = 0; c < NCH; c++) begin
        rem_q[c] <= 16'h0;
        src_q[c] <= 16'h0;
        dst_q[c] <= 16'h0;
      end
    end else begin
      done_ev <= '0;
      for (int c = 0; c < NCH; c++) begin
        // disabled channel drops triggers and pending work
        if (!ctrl_q[c][F_EN]) begin
          pend_q[c] <= 1'b0;
          busy_q[c] <= 1'b0;
        end else if (hit[c] && !busy_q[c]) begin
          pend_q[c] <= 1'b1;
          busy_q[c] <= 1'b1;
          if (rem_q[c] == 16'h0) rem_q[c] <= cnt_q[c];
        end
        if (ram_we && ch_of(avs_address) == CW'(c)) begin
          if (reg_sel(avs_address) == CH_SRC) src_q[c] <= ram_wd;
          else dst_q[c] <= ram_wd;
        end
      end
      if (st_q == S_IDLE && any_pend) pend_q[win] <= 1'b0;
      if (lim_err) begin
        busy_q[cur_q] <= 1'b0;
        rem_q[cur_q] <= 16'h0;
      end else if (step_now) begin
        rem_q[cur_q] <= rem_q[cur_q] - 16'h1;
        if (last || !ctrl_q[cur_q][F_EN]) begin
          busy_q[cur_q] <= 1'b0; // one trigger, one series
          done_ev[cur_q] <= last;
          rem_q[cur_q] <= 16'h0;
          // reload of base addresses: optional, forced in repeated modes
          if (!(ctrl_q[cur_q][F_RELOAD] || cur_mode == M_REP_ONE
                || cur_mode == M_REP_CONT)) begin
            src_q[cur_q] <= step(sa_q, ctrl_q[cur_q][F_SAM+:2], !ctrl_q[cur_q][F_SIZE]);
            dst_q[cur_q] <= step(da_q, ctrl_q[cur_q][F_DAM+:2], !ctrl_q[cur_q][F_SIZE]);
          end
        end
      end
    end
  end

  // ==========================================================================
  // enable stays set after a block in every mode, one-shot or repeated; only a bus write clears it
  // sticky status, set wins over write-one clear
  logic [2*NCH-1:0] ev, stat_d;
  always_comb begin
    ev = '0;
    ev[NCH-1:0] = done_ev;
    if (lim_err) ev[NCH + int'(cur_q)] = 1'b1;
    stat_d = stat_q | ev;
    if (is_wr && avs_address == G_STATUS) stat_d = (stat_q & ~avs_writedata[2*NCH-1:0]) | ev;
  end
  // irq follows the next status, so a clear drops it at the same edge
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      stat_q <= '0;
      o_irq <= 1'b0;
    end else begin
      stat_q <= stat_d;
      o_irq <= |(stat_d & mask_q);
    end
  end

  // ==========================================================================
  // checks
  sequence s_wr_issue;
    st_q == S_WRITE && o_ds.req && o_ds.we;
  endsequence
  chk_size_reset: assert property (@(posedge i_mclk) $rose(i_rst_n) |-> ctrl_q[0][F_SIZE])
    else $error("size not word after reset");
  chk_limit_abort: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    lim_err |=> st_q == S_IDLE && stat_q[NCH + int'($past(cur_q))]) else $error("no abort");
  chk_byte_lane: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_wr_issue and !ctrl_q[cur_q][F_SIZE] |-> o_ds.be == (o_ds.addr[0] ? 2'b10 : 2'b01))
    else $error("wrong byte lane");
  chk_arb_order: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    st_q == S_IDLE && pend_q[0] && ctrl_q[0][F_EN] |=> cur_q == '0) else $error("priority lost");
  chk_disable_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !ctrl_q[1][F_EN] |=> !pend_q[1]) else $error("disabled channel pending");
  chk_done_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    done_ev[0] |=> stat_q[0]) else $error("completion flag lost");
  chk_irq_level: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    |(stat_q & mask_q) |-> ##[0:1] o_irq) else $error("interrupt not raised");
  chk_oneshot_end: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    step_now && !cur_cont |=> st_q == S_IDLE) else $error("one-shot ran on");
  chk_cont_next: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    step_now && !last && ctrl_q[cur_q][F_EN] |=> st_q == S_READ) else $error("series cut");
endmodule // dma_ctrl
`default_nettype wire

// ---- rtl/dma_pkg.sv ----
package dma_pkg;
  // ==========================================================================
  // register map: byte offsets within a channel window, then global registers at 8'h80 and up
  localparam logic [7:0] CH_CTRL   = 8'h00; // channel_control_register
  localparam logic [7:0] CH_TRIG   = 8'h04;
  localparam logic [7:0] CH_SRC    = 8'h08;
  localparam logic [7:0] CH_DST    = 8'h0c;
  localparam logic [7:0] CH_CNT    = 8'h10; // transaction_count_register
  localparam logic [7:0] CH_STRIDE = 8'h20; // bytes per channel window
  localparam logic [7:0] G_LOWER   = 8'h80; // lower_address_limit
  localparam logic [7:0] G_UPPER   = 8'h84; // upper_address_limit
  localparam logic [7:0] G_STATUS  = 8'h88;
  localparam logic [7:0] G_MASK    = 8'h8c;
  // ==========================================================================
  // control fields
  localparam int F_EN = 0;
  localparam int F_SIZE = 1;
  localparam int F_MODE = 2; // two bits
  localparam int F_RELOAD = 4;
  localparam int F_SAM = 5; // two bits: 0 fixed,1 inc,2 dec
  localparam int F_DAM = 7;
  localparam int F_SIND = 9;
  localparam int F_DIND = 10;
  localparam logic [15:0] CTRL_RESET = 16'h0002; // word size
  localparam logic [15:0] SFR_TOP = 16'h07ff;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam int N_TRIG = 63;
  typedef enum logic [1:0] {M_ONESHOT=2'h0, M_CONT=2'h1, M_REP_ONE=2'h2, M_REP_CONT=2'h3} mode_t;
  typedef enum logic [1:0] {S_IDLE=2'b00, S_READ=2'b01, S_WRITE=2'b11, S_STEP=2'b10} xfer_state_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } ds_req_t;
endpackage

// ---- rtl/dma_regram.sv ----
`timescale 1ns/1ps
`default_nettype none
// small register-file memory, registered read data
module dma_regram #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          i_mclk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [15:0]   i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [15:0]   o_rdata
);
  logic [15:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) $error("depth exceeds address range");
  end
  // ==========================================================================
  // write port and registered read
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // dma_regram
`default_nettype wire

// ---- bench/ds_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// =============================================
// data space stand-in: registers and ram as one word array
module ds_model (
  input  wire logic             i_mclk,
  input  wire logic [1:0]       i_lat,
  input  wire dma_pkg::ds_req_t i_ds,
  output logic                  o_ack,
  output logic      [15:0]      o_rdata
);
  import dma_pkg::*;
  logic [15:0] mem [0:32767];
  logic [1:0]  wait_q = 2'h0;
  initial o_ack = 1'b0;
  initial o_rdata = 16'h5a5a;
  // one ack per request, then a gap so a held request is not acked twice
  always @(posedge i_mclk) begin
    if (o_ack || !i_ds.req) begin
      o_ack <= 1'b0;
      wait_q <= 2'h0;
      o_rdata <= ~o_rdata; // no stale data between answers
    end else if (wait_q >= i_lat) begin
      o_ack <= 1'b1;
      if (i_ds.we && i_ds.be[0]) mem[i_ds.addr[15:1]][7:0] <= i_ds.wdata[7:0];
      if (i_ds.we && i_ds.be[1]) mem[i_ds.addr[15:1]][15:8] <= i_ds.wdata[15:8];
      if (!i_ds.we) o_rdata <= mem[i_ds.addr[15:1]];
    end else begin
      wait_q <= wait_q + 2'h1;
      o_rdata <= ~o_rdata;
    end
  end
endmodule // ds_model
`default_nettype wire

// ---- bench/multi_channel_dma_controller_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module multi_channel_dma_controller_test;
  import dma_pkg::*;
  logic        i_mclk        = 1'b0;
  logic        i_rst_n       = 1'b0;
  logic [7:0]  avs_address   = 8'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [62:0] i_trig        = 63'h0;
  logic [15:0] i_adc_offset  = 16'h0;
  logic [1:0]  lat           = 2'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  ds_req_t     o_ds;
  logic        i_ds_ack;
  logic [15:0] i_ds_rdata;
  logic        o_irq;
  logic [31:0] rd;
  int          err_total     = 0;
  int          checks_done   = 0;

  dma_ctrl #(.NCH(4)) dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .i_trig(i_trig),
    .i_adc_offset(i_adc_offset), .o_ds(o_ds), .i_ds_ack(i_ds_ack),
    .i_ds_rdata(i_ds_rdata), .o_irq(o_irq));
  ds_model part_u (.i_mclk(i_mclk), .i_lat(lat), .i_ds(o_ds), .o_ack(i_ds_ack),
    .o_rdata(i_ds_rdata));

  // 125 mhz
  always #4 i_mclk = ~i_mclk;

  // =============================================
  // shared helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge i_mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge i_mclk);
      n++;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge i_mclk); // idle cycle the slave needs
  endtask

  task automatic prog(input int ch, input logic [15:0] ctl, input logic [5:0] trg,
                      input logic [15:0] s, input logic [15:0] d, input logic [15:0] c);
    logic [7:0] b;
    b = 8'(ch * 32);
    bus(1'b1, b + CH_SRC, {16'h0, s});
    bus(1'b1, b + CH_DST, {16'h0, d});
    bus(1'b1, b + CH_CNT, {16'h0, c});
    bus(1'b1, b + CH_TRIG, {26'h0, trg});
    bus(1'b1, b + CH_CTRL, {16'h0, ctl});
  endtask

  // trigger n sits at bit 62-n; held long enough to pass the synchroniser
  task automatic fire(input int trg);
    i_trig[62 - trg] <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_trig <= 63'h0;
  endtask

  // poll status until the bit sets, then clear it by writing one
  task automatic wait_st(input int bitn);
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[bitn] !== 1'b1 && n < 100) begin
      bus(1'b0, G_STATUS, 32'h0);
      n++;
    end
    check(32'(rd[bitn]), 32'h1);
    check(32'(o_irq), 32'h1); // irq follows the unmasked bit
    bus(1'b1, G_STATUS, 32'h1 << bitn);
    check(32'(o_irq), 32'h0);
  endtask

  // =============================================
  // scenarios
  task automatic t_reset;
    bus(1'b0, CH_CTRL, 32'h0);
    check(rd, {16'h0, CTRL_RESET});
    bus(1'b0, G_LOWER, 32'h0);
    check(rd, 32'h0800);
    bus(1'b0, G_UPPER, 32'h0);
    check(rd, 32'hffff);
    bus(1'b1, 8'h7c, 32'hffff);
    bus(1'b0, 8'h7c, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, G_MASK, 32'h0000_00ff);
  endtask

  // one-shot moves one word per trigger only, register region to ram
  task automatic t_oneshot;
    int n;
    part_u.mem[15'h0080] = 16'h1234;
    part_u.mem[15'h0081] = 16'h5678;
    part_u.mem[15'h0480] = 16'h0;
    part_u.mem[15'h0481] = 16'h0;
    prog(0, 16'h00a3, 6'd10, 16'h0100, 16'h0900, 16'h0002);
    fire(10);
    n = 0;
    while (part_u.mem[15'h0480] !== 16'h1234 && n < 200) begin
      @(posedge i_mclk);
      n++;
    end
    wait_st(0);
    check(32'(part_u.mem[15'h0480]), 32'h1234);
    check(32'(part_u.mem[15'h0481]), 32'h0);
    fire(10);
    wait_st(0);
    check(32'(part_u.mem[15'h0481]), 32'h5678);
  endtask

  // continuous block, source up and destination down, slow far side
  task automatic t_block;
    lat <= 2'h3;
    for (int i = 0; i < 4; i++) part_u.mem[15'h0500 + 15'(i)] = 16'h00c0 + 16'(i);
    part_u.mem[15'h057f] = 16'h0;
    prog(1, 16'h0127, 6'd20, 16'h0a00, 16'h0b04, 16'h0003);
    fire(20);
    wait_st(1);
    for (int i = 0; i < 3; i++) check(32'(part_u.mem[15'h0582 - 15'(i)]), 32'h00c0 + i);
    check(32'(part_u.mem[15'h057f]), 32'h0);
    lat <= 2'h0;
  endtask

  // byte size: odd source takes the upper lane into the lower lane
  task automatic t_byte;
    part_u.mem[15'h0600] = 16'hab12;
    part_u.mem[15'h0680] = 16'h7777;
    prog(2, 16'h0001, 6'd62, 16'h0c01, 16'h0d00, 16'h0001);
    fire(62);
    wait_st(2);
    check(32'(part_u.mem[15'h0680]), 32'h77ab);
  endtask

  // destination beyond the upper limit aborts and flags an error
  task automatic t_limit;
    part_u.mem[15'h1000] = 16'h0;
    bus(1'b1, G_UPPER, 32'h0fff);
    prog(3, 16'h0003, 6'd0, 16'h0100, 16'h2000, 16'h0001);
    fire(0);
    wait_st(7);
    check(32'(part_u.mem[15'h1000]), 32'h0);
    bus(1'b1, G_UPPER, 32'hffff);
  endtask

  // converter offset added to the destination base
  task automatic t_indirect;
    i_adc_offset <= 16'h0006;
    prog(0, 16'h0403, 6'd33, 16'h0100, 16'h0e00, 16'h0001);
    fire(33);
    wait_st(0);
    check(32'(part_u.mem[15'h0703]), 32'h1234);
  endtask

  // =============================================
  // verdict and run control
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    t_reset();
    t_oneshot();
    t_block();
    t_byte();
    t_limit();
    t_indirect();
    stop_test();
  end
endmodule // multi_channel_dma_controller_test
`default_nettype wire
